// ==== hw/rbp_pkg.sv ====
// constants shared by the registered buffer with parity check
// Functional notes
// - reset clears registers, outputs low, error high
// - reset acts asynchronously, no clock needed
// - inputs ignored while reset is low
// - outputs stay low after release, inputs low
// - parity arrives one cycle after its data
// - error driven at m+2, valid by m+3
// - check covers mode-dependent independent data bits
// - even parity over data plus parity bit
// - error output is active low, open drain
// - error stays low at least two cycles
// - consecutive errors keep error low throughout
// - low power state freezes data and error outputs
// - error before low power held plus two
// - clock enables, terminations, selects not checked
// - pinout mode static: low A, high B
// - gate plus first two selects high hold data
// - otherwise data outputs follow inputs
// - all four selects high freeze error output
// - reset overrides select gating
// - gate enable low disables data output gating only
// - selects two, three gate but not redriven
// - selects, clock enables, terminations always registered
package rbp_pkg;

	// ***************************************************
	// widths
	// ***************************************************
	localparam int DATA_W = 28;
	localparam int SEL_W = 4;
	localparam int BANKS = 2;

	// ***************************************************
	// parity masks, bit 0 is the first data input
	// ***************************************************
	localparam logic [DATA_W-1:0] PAR_MASK_A = 28'h0FFF0F5F;
	localparam logic [DATA_W-1:0] PAR_MASK_B = 28'h0FAF0FFF;

	// ***************************************************
	// reset values
	// ***************************************************
	localparam logic [DATA_W-1:0] DATA_RST = 28'h0000000;
	localparam logic [1:0] PAIR_RST = 2'h0;
	localparam logic ERR_N_RST = 1'h1;

	// ***************************************************
	// timing counts in clock cycles
	// ***************************************************
	localparam logic [1:0] ERR_HOLD_CYCLES = 2'h2;
	localparam logic [1:0] LPM_TAIL_CYCLES = 2'h2;

endpackage

// ==== hw/rbp_parity_tree.sv ====
// masked even-parity reduction over the command and address word
`timescale 1ns/100ps
module rbp_parity_tree
	import rbp_pkg::*;
(
	input wire logic [DATA_W-1:0] data_i,
	input wire logic config_b_i,
	output logic parity_o
);

	// ***************************************************
	// mask selection
	// ***************************************************
	// module-dependent positions drop out of the sum
	wire [DATA_W-1:0] sel_mask;
	wire [DATA_W-1:0] masked;

	assign sel_mask = config_b_i ? PAR_MASK_B : PAR_MASK_A;
	assign masked = data_i & sel_mask;

	// ***************************************************
	// reduction
	// ***************************************************
	// odd count of ones yields a one here
	assign parity_o = ^masked;

endmodule

// ==== hw/rbp_registered_buffer.sv ====
// registered command buffer with parity check and select gating
`timescale 1ns/100ps
module rbp_registered_buffer
	import rbp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic config_b_i,
	input wire logic select_gate_enable_i,
	input wire logic [DATA_W-1:0] buffer_in_i,
	input wire logic parity_bit_in_i,
	input wire logic [SEL_W-1:0] rank_selects_n_i,
	input wire logic [1:0] power_down_in_i,
	input wire logic [1:0] termination_in_i,
	output logic [DATA_W-1:0] registered_out_a_o,
	output logic [DATA_W-1:0] registered_out_b_o,
	output logic [1:0] redriven_select_out_a_o,
	output logic [1:0] redriven_select_out_b_o,
	output logic [1:0] power_down_out_a_o,
	output logic [1:0] power_down_out_b_o,
	output logic [1:0] termination_out_a_o,
	output logic [1:0] termination_out_b_o,
	output logic parity_error_n_o,
	output logic parity_error_oe_o
);

	// ***************************************************
	// gating decode
	// ***************************************************
	// the gate enable tied low removes data gating entirely
	wire data_gate;
	wire err_gate;
	wire low_power_state;

	assign data_gate = select_gate_enable_i & rank_selects_n_i[0]
		& rank_selects_n_i[1];
	assign err_gate = &rank_selects_n_i;
	assign low_power_state = select_gate_enable_i & err_gate;

	// ***************************************************
	// output banks
	// ***************************************************
	// each bank has its own flops so both drivers switch together
	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank
			logic [DATA_W-1:0] q_data;
			logic [1:0] q_sel;
			logic [1:0] q_pd;
			logic [1:0] q_term;

			// async clear so the outputs fall without a clock
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					q_data <= DATA_RST;
				end else if (!data_gate) begin
					q_data <= buffer_in_i;
				end
			end

			// control copies keep running while data is gated
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					q_sel <= PAIR_RST;
					q_pd <= PAIR_RST;
					q_term <= PAIR_RST;
				end else begin
					q_sel <= rank_selects_n_i[1:0];
					q_pd <= power_down_in_i;
					q_term <= termination_in_i;
				end
			end

			if (b == 0) begin : g_port_a
				assign registered_out_a_o = q_data;
				assign redriven_select_out_a_o = q_sel;
				assign power_down_out_a_o = q_pd;
				assign termination_out_a_o = q_term;
			end else begin : g_port_b
				assign registered_out_b_o = q_data;
				assign redriven_select_out_b_o = q_sel;
				assign power_down_out_b_o = q_pd;
				assign termination_out_b_o = q_term;
			end
		end
	endgenerate

	// ***************************************************
	// parity pipeline
	// ***************************************************
	// data is taken at edge m, its parity bit at edge m+1
	logic [DATA_W-1:0] chk_data;
	logic data_par;
	logic par_q;
	wire chk_parity;
	wire parity_fail;

	rbp_parity_tree u_parity_tree (
		.data_i(chk_data),
		.config_b_i(config_b_i),
		.parity_o(chk_parity)
	);

	// the check word is captured even while data outputs are gated
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chk_data <= DATA_RST;
		end else begin
			chk_data <= buffer_in_i;
		end
	end

	// parity of the earlier word meets the later parity bit
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_par <= 1'h0;
			par_q <= 1'h0;
		end else begin
			data_par <= chk_parity;
			par_q <= parity_bit_in_i;
		end
	end

	assign parity_fail = data_par ^ par_q;

	// ***************************************************
	// error latch
	// ***************************************************
	// hold_cnt counts the extra low cycles still owed
	logic err_n;
	logic err_oe;
	logic [1:0] hold_cnt;
	logic lpm_seen;
	wire hold_active;
	wire lpm_tail;
	wire next_err_n;
	wire [1:0] next_hold_cnt;
	wire next_lpm_seen;

	assign hold_active = (hold_cnt != 2'h0);
	assign lpm_tail = lpm_seen & ~err_n;

	// a frozen error output ignores the checker, new errors win
	assign next_err_n = err_gate ? err_n :
		parity_fail ? 1'h0 :
		(lpm_tail | (hold_active & ~err_n)) ? 1'h0 :
		1'h1;

	assign next_hold_cnt = err_gate ? hold_cnt :
		parity_fail ? ERR_HOLD_CYCLES - 2'h1 :
		lpm_tail ? LPM_TAIL_CYCLES - 2'h1 :
		hold_active ? hold_cnt - 2'h1 :
		2'h0;

	// remembers that the freeze began with the error asserted
	assign next_lpm_seen = err_gate ? (lpm_seen | ~err_n) : 1'h0;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			err_n <= ERR_N_RST;
			err_oe <= 1'h0;
			hold_cnt <= 2'h0;
			lpm_seen <= 1'h0;
		end else begin
			err_n <= next_err_n;
			err_oe <= ~next_err_n;
			hold_cnt <= next_hold_cnt;
			lpm_seen <= next_lpm_seen;
		end
	end

	// the pin is pulled low only; oe marks when it is driven
	assign parity_error_n_o = err_n;
	assign parity_error_oe_o = err_oe;

	// ***************************************************
	// assertions
	// ***************************************************
	default clocking cb_sys @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	wire [DATA_W-1:0] cur_mask;
	assign cur_mask = config_b_i ? PAR_MASK_B : PAR_MASK_A;

	// the first edge of power-up reset may still see unknown flops
	a_reset_clears_out: assert property (
		@(posedge clk_sys_i) disable iff (1'b0)
		(!rst_n_i ##1 !rst_n_i) |-> (registered_out_a_o == DATA_RST)
			&& (registered_out_b_o == DATA_RST)
			&& (power_down_out_a_o == PAIR_RST)
			&& parity_error_n_o && !parity_error_oe_o)
		else $error("outputs not cleared during reset");

	a_parity_latency: assert property (
		($past(rst_n_i, 3) && !err_gate
			&& ((^($past(buffer_in_i, 2) & cur_mask))
			^ $past(parity_bit_in_i, 1)))
		|=> !parity_error_n_o)
		else $error("parity error not reported at m+2");

	a_err_min_low: assert property (
		$fell(parity_error_n_o) |=> !parity_error_n_o)
		else $error("error output low for under two cycles");

	a_err_release: assert property (
		(!parity_error_n_o && !hold_active && !parity_fail
			&& !err_gate && !lpm_seen)
		|=> parity_error_n_o)
		else $error("error output not released");

	a_err_gate_hold: assert property (
		err_gate |=> $stable(parity_error_n_o))
		else $error("error output changed while frozen");

	a_data_gate_hold: assert property (
		data_gate |=> $stable(registered_out_a_o)
			&& $stable(registered_out_b_o))
		else $error("data outputs changed while gated");

	a_data_follow: assert property (
		!data_gate |=> registered_out_a_o == $past(buffer_in_i))
		else $error("data output did not follow input");

	a_select_follow: assert property (
		rank_selects_n_i[1:0] == 2'h3 |=>
			redriven_select_out_a_o == 2'h3
			&& redriven_select_out_b_o == 2'h3)
		else $error("select outputs not registered");

	a_bank_match: assert property (
		(registered_out_a_o == registered_out_b_o)
			&& (termination_out_a_o == termination_out_b_o)
			&& (power_down_out_a_o == power_down_out_b_o))
		else $error("output banks disagree");

	a_lpm_tail: assert property (
		(err_gate && !parity_error_n_o ##1 !err_gate)
		|=> !parity_error_n_o [*2])
		else $error("error not held two cycles after freeze");

	a_oe_pair: assert property (
		parity_error_oe_o == !parity_error_n_o)
		else $error("open drain enable mismatch");

	// ***************************************************
	// pass-through, reset and latch checks
	// ***************************************************
	// attempts start one edge into reset release so $past sees live data
	wire [1:0] sel_in;
	assign sel_in = rank_selects_n_i[1:0];

	a_select_copy: assert property (
		rst_n_i |=> (redriven_select_out_a_o == $past(sel_in))
			&& (redriven_select_out_b_o == $past(sel_in)))
		else $error("select outputs not registered each edge");

	a_power_copy: assert property (
		rst_n_i |=> (power_down_out_a_o == $past(power_down_in_i))
			&& (power_down_out_b_o == $past(power_down_in_i)))
		else $error("clock enable outputs not registered");

	a_term_copy: assert property (
		rst_n_i |=> (termination_out_a_o == $past(termination_in_i))
			&& (termination_out_b_o == $past(termination_in_i)))
		else $error("termination outputs not registered");

	a_power_gated: assert property (
		data_gate |=> power_down_out_a_o == $past(power_down_in_i))
		else $error("clock enable output held while data gated");

	a_follow_b: assert property (
		!data_gate |=> registered_out_b_o == $past(buffer_in_i))
		else $error("second bank did not follow input");

	a_gate_off_follow: assert property (
		!select_gate_enable_i |=>
			registered_out_b_o == $past(buffer_in_i))
		else $error("data held although gating is off");

	a_lpm_freeze: assert property (
		low_power_state |=> $stable(registered_out_a_o)
			&& $stable(parity_error_n_o))
		else $error("outputs changed in low power state");

	a_upper_freeze: assert property (
		err_gate |=> $stable(parity_error_oe_o))
		else $error("error enable changed while frozen");

	// the even-parity twin of the latency check, also gated on hold_active and lpm_seen
	a_parity_clean: assert property (
		($past(rst_n_i, 3) && !err_gate && !hold_active && !lpm_seen
			&& !((^($past(buffer_in_i, 2) & cur_mask))
			^ $past(parity_bit_in_i, 1)))
		|=> parity_error_n_o)
		else $error("error raised for even parity");

	a_err_two_low: assert property (
		$rose(parity_error_n_o) |-> !$past(parity_error_n_o, 2))
		else $error("error output released too early");

	// internal bookkeeping must agree with the pin
	a_hold_owed: assert property (
		hold_active |-> !parity_error_n_o)
		else $error("hold count running with error released");

	a_tail_flag: assert property (
		lpm_seen |-> !parity_error_n_o)
		else $error("freeze tail flag set with error released");

	a_lpm_tail_oe: assert property (
		(err_gate && !parity_error_n_o ##1 !err_gate)
		|=> parity_error_oe_o [*2])
		else $error("enable dropped before freeze tail ended");

	a_release_quiet: assert property (
		(!$past(rst_n_i) && (buffer_in_i == DATA_RST))
		|=> (registered_out_a_o == DATA_RST) && parity_error_n_o)
		else $error("outputs moved right after reset release");

	// selects are held high through reset to prove the override
	a_reset_priority: assert property (
		@(posedge clk_sys_i) disable iff (1'h0)
		(!rst_n_i ##1 !rst_n_i) |-> (registered_out_b_o == DATA_RST)
			&& (redriven_select_out_a_o == PAIR_RST)
			&& (redriven_select_out_b_o == PAIR_RST)
			&& (termination_out_a_o == PAIR_RST)
			&& (power_down_out_b_o == PAIR_RST))
		else $error("reset lost to select gating");

	c_parity_error: cover property (
		parity_error_n_o ##1 !parity_error_n_o);

	c_back_to_back: cover property (
		parity_fail && !err_gate ##1 parity_fail && !err_gate);

	c_low_power: cover property (
		!parity_error_n_o && low_power_state ##1 !low_power_state);

	c_data_gated: cover property (data_gate && !err_gate);

	c_freeze_tail: cover property (
		err_gate && !parity_error_n_o ##1 !err_gate);

endmodule

// ==== dv/rbp_ctrl_model.sv ====
// controller model driving command words and their trailing parity
`timescale 1ns/100ps
module rbp_ctrl_model
	import rbp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic config_b_i,
	input wire logic run_i,
	input wire logic inject_i,
	input wire logic [DATA_W-1:0] word_i,
	output logic [DATA_W-1:0] buffer_in_o,
	output logic parity_bit_in_o
);
	logic [DATA_W-1:0] mask;
	assign mask = config_b_i ? PAR_MASK_B : PAR_MASK_A;
	initial begin
		buffer_in_o = '0;
		parity_bit_in_o = 1'b0;
	end
	// parity trails its word by one edge; inject corrupts it on purpose
	always @(posedge clk_sys_i) begin
		buffer_in_o <= run_i ? word_i : '0;
		parity_bit_in_o <= run_i & (^(buffer_in_o & mask) ^ inject_i);
	end
endmodule

// ==== dv/test_registered_buffer_parity_check.sv ====
// self-checking bench for the registered buffer with parity check
`timescale 1ns/100ps
module test_registered_buffer_parity_check
	import rbp_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_n = 1'b0;
	logic cfg = 1'b0;
	logic gate = 1'b0;
	logic run = 1'b0;
	logic inject = 1'b0;
	logic chk_on = 1'b0;
	logic [SEL_W-1:0] rs = '0;
	logic [1:0] pd = '0;
	logic [1:0] term = '0;
	logic [DATA_W-1:0] word = '0;
	logic [DATA_W-1:0] din, qa, qb, eq, ed;
	logic par, err_n, oe, efail, eerr;
	logic [1:0] sa, sb, pa, pb, ta, tb, esel, epd, eterm, ecnt;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	integer seed = 32'hA952F2E1;
	always #10 clk_sys_i = ~clk_sys_i;
	rbp_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .config_b_i(cfg),
		.run_i(run), .inject_i(inject), .word_i(word),
		.buffer_in_o(din), .parity_bit_in_o(par));
	rbp_registered_buffer dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n),
		.config_b_i(cfg), .select_gate_enable_i(gate), .buffer_in_i(din),
		.parity_bit_in_i(par), .rank_selects_n_i(rs),
		.power_down_in_i(pd), .termination_in_i(term),
		.registered_out_a_o(qa), .registered_out_b_o(qb),
		.redriven_select_out_a_o(sa), .redriven_select_out_b_o(sb),
		.power_down_out_a_o(pa), .power_down_out_b_o(pb),
		.termination_out_a_o(ta), .termination_out_b_o(tb),
		.parity_error_n_o(err_n), .parity_error_oe_o(oe));
	// ***************************************************
	// reference model
	// ***************************************************
	function automatic logic fail_of(input logic [DATA_W-1:0] d,
		input logic p, input logic c);
		return ^(d & (c ? PAR_MASK_B : PAR_MASK_A)) ^ p;
	endfunction
	// a freeze begun while low leaves two more low edges after it ends
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			{eq, ed, esel, epd, eterm, efail, ecnt} <= '0;
			eerr <= 1'b1;
		end else begin
			if (!(gate & rs[0] & rs[1]))
				eq <= din;
			esel <= rs[1:0];
			epd <= pd;
			eterm <= term;
			ed <= din;
			efail <= fail_of(ed, par, cfg);
			if (rs == 4'hF) begin
				if (!eerr)
					ecnt <= 2'h2;
			end else if (efail) begin
				eerr <= 1'b0;
				ecnt <= 2'h1;
			end else if (ecnt != 2'h0)
				ecnt <= ecnt - 2'h1;
			else
				eerr <= 1'b1;
		end
	end
	task automatic check(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	always @(negedge clk_sys_i) begin
		if (chk_on) begin
			check("registered_out_a", eq, qa);
			check("registered_out_b", eq, qb);
			check("redriven_select", {esel, esel}, {sa, sb});
			check("power_down", {epd, epd}, {pa, pb});
			check("termination", {eterm, eterm}, {ta, tb});
			check("parity_error_n", eerr, err_n);
			check("parity_error_oe", !eerr, oe);
		end
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles >= 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic traffic(input int n, input logic g, input int erate,
		input logic sel_on);
		repeat (n) begin
			@(posedge clk_sys_i);
			word <= DATA_W'($random(seed));
			inject <= (($random(seed) & 32'hFF) < erate);
			gate <= g;
			pd <= 2'($random(seed));
			term <= 2'($random(seed));
			if (!sel_on)
				rs <= '0;
			else if (($random(seed) & 3) == 0)
				rs <= 4'hF;
			else
				rs <= SEL_W'($random(seed));
		end
	endtask
	// reset lands between edges on purpose; all selects are driven high one edge later, while it is held
	task automatic do_reset(input logic c);
		@(posedge clk_sys_i);
		#7 rst_n = 1'b0;
		#1 check("reset_data", '0, qa);
		check("reset_error_n", 1'b1, err_n);
		@(posedge clk_sys_i);
		{gate, rs, run, inject} <= 7'h7C;
		cfg <= c;
		repeat (16) @(posedge clk_sys_i);
		{rst_n, gate, rs} <= 6'h20;
		repeat (4) @(posedge clk_sys_i);
		run <= 1'b1;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_n <= 1'b1;
		chk_on <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		run <= 1'b1;
		traffic(300, 1'b0, 20, 1'b1);
		traffic(300, 1'b1, 20, 1'b1);
		traffic(40, 1'b1, 256, 1'b0);
		traffic(20, 1'b0, 0, 1'b0);
		// error on the cycle just before a long low-power stretch
		@(posedge clk_sys_i);
		inject <= 1'b1;
		@(posedge clk_sys_i);
		inject <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		{gate, rs} <= 5'h1F;
		repeat (6) @(posedge clk_sys_i);
		rs <= '0;
		traffic(10, 1'b0, 0, 1'b0);
		do_reset(1'b1);
		traffic(300, 1'b1, 30, 1'b1);
		do_reset(1'b0);
		traffic(100, 1'b0, 30, 1'b1);
		report_and_stop();
	end
endmodule
